// ==== design/asrf_fifo.sv ====
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module asrf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;
    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready && ce;
    assign pop = out_valid && out_ready && ce;
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// ==== design/asrf_framer.sv ====
// api status and response frame builder, byte stream out through a fifo
`timescale 1ns/1ps
module asrf_framer
    import asrf_pkg::*;
(
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // command response request
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [7:0] cmd_frame_id,
    input wire logic [15:0] cmd_name,
    input wire logic [7:0] cmd_status,
    input wire logic cmd_has_data,
    input wire logic [3:0] cmd_data_len,
    input wire logic [63:0] cmd_data,
    // modem status request
    input wire logic modem_valid,
    output logic modem_ready,
    input wire logic [7:0] modem_code,
    // transmit status request
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_frame_id,
    input wire logic tx_ok,
    input wire logic tx_broadcast,
    input wire logic [15:0] tx_addr,
    input wire logic [7:0] tx_retries,
    input wire logic [7:0] tx_delivery,
    input wire logic [7:0] tx_discovery,
    // serial byte stream
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_data,
    output logic out_last
);
    typedef enum logic [3:0] {
        ASRF_ST_IDLE = 4'b0001,
        ASRF_ST_HEAD = 4'b0010,
        ASRF_ST_DATA = 4'b0100,
        ASRF_ST_SUM = 4'b1000
    } asrf_state_t;

    logic rst_n;
    logic rst_sync_q;
    logic take;
    logic boot_pending_q;
    asrf_state_t state_q;
    asrf_kind_t kind_q;
    logic [4:0] ofs_q;
    logic [3:0] dcnt_q;
    logic [3:0] dlen_q;
    logic [7:0] sum_q;
    logic [7:0] fid_q;
    logic [15:0] word_q;
    logic [7:0] b7_q;
    logic [7:0] b8_q;
    logic [7:0] b9_q;
    logic [63:0] data_q;
    logic [15:0] len_q;
    logic [7:0] byte_c;
    logic fifo_in_ready;
    logic fifo_in_valid;
    logic fifo_out_valid;
    logic [8:0] fifo_out;
    logic emit;
    logic head_last;
    logic idle;

    // reset released through two flops so all logic leaves reset together
    asrf_sync u_rst_sync (
        .clk(ref_clk),
        .rst_n(reset_n),
        .d(1'b1),
        .q(rst_sync_q)
    );
    assign rst_n = rst_sync_q;

    assign idle = (state_q == ASRF_ST_IDLE);
    // boot status goes first, so every other source waits until it is queued
    assign modem_ready = idle && !boot_pending_q && clk_en;
    assign tx_ready = idle && !boot_pending_q && !modem_valid && clk_en;
    assign cmd_ready = idle && !boot_pending_q && !modem_valid && !tx_valid && clk_en;
    assign fifo_in_valid = !idle;
    assign emit = fifo_in_valid && fifo_in_ready && clk_en;
    assign head_last = (kind_q == ASRF_KIND_MODEM) ? (ofs_q == ASRF_OFS_ID) :
                       (kind_q == ASRF_KIND_TX) ? (ofs_q == ASRF_OFS_F9) : (ofs_q == ASRF_OFS_F7);

    // byte for the current offset
    always_comb begin
        byte_c = 8'h00;
        unique case (state_q)
            ASRF_ST_HEAD: begin
                if (ofs_q == 5'h00) begin
                    byte_c = ASRF_DELIM;
                end else if (ofs_q == ASRF_OFS_LEN_MSB) begin
                    byte_c = len_q[15:8];
                end else if (ofs_q == ASRF_OFS_LEN_LSB) begin
                    byte_c = len_q[7:0];
                end else if (ofs_q == ASRF_OFS_TYPE) begin
                    byte_c = (kind_q == ASRF_KIND_CMD) ? ASRF_TYPE_CMD_RESP :
                             (kind_q == ASRF_KIND_MODEM) ? ASRF_TYPE_MODEM : ASRF_TYPE_TX_STAT;
                end else if (ofs_q == ASRF_OFS_ID) begin
                    byte_c = fid_q;
                end else if (ofs_q == ASRF_OFS_F5) begin
                    byte_c = word_q[15:8];
                end else if (ofs_q == ASRF_OFS_F6) begin
                    byte_c = word_q[7:0];
                end else if (ofs_q == ASRF_OFS_F7) begin
                    byte_c = b7_q;
                end else if (ofs_q == ASRF_OFS_F8) begin
                    byte_c = b8_q;
                end else begin
                    byte_c = b9_q;
                end
            end
            ASRF_ST_DATA: byte_c = data_q[63:56];
            ASRF_ST_SUM: byte_c = ASRF_CKSUM_BASE - sum_q;
            default: byte_c = 8'h00;
        endcase
    end

    // boot flag: cleared once the hardware reset status is taken
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_pending_q <= 1'b1;
        end else if (clk_en && idle && boot_pending_q) begin
            boot_pending_q <= 1'b0;
        end
    end

    // frame sequencer; each accepted event makes its own frame, except transmit and command requests with frame id zero
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ASRF_ST_IDLE;
            kind_q <= ASRF_KIND_MODEM;
            ofs_q <= 5'h00;
            dcnt_q <= 4'h0;
            dlen_q <= 4'h0;
            sum_q <= 8'h00;
            fid_q <= 8'h00;
            word_q <= 16'h0000;
            b7_q <= 8'h00;
            b8_q <= 8'h00;
            b9_q <= 8'h00;
            data_q <= 64'h0;
            len_q <= 16'h0000;
        end else if (clk_en) begin
            unique case (state_q)
                ASRF_ST_IDLE: begin
                    ofs_q <= 5'h00;
                    sum_q <= 8'h00;
                    if (boot_pending_q) begin
                        kind_q <= ASRF_KIND_MODEM;
                        fid_q <= ASRF_MS_HW_RESET;
                        len_q <= ASRF_LEN_MODEM;
                        state_q <= ASRF_ST_HEAD;
                    end else if (modem_valid) begin
                        kind_q <= ASRF_KIND_MODEM;
                        fid_q <= modem_code;
                        len_q <= ASRF_LEN_MODEM;
                        state_q <= ASRF_ST_HEAD;
                    end else if (tx_valid) begin
                        kind_q <= ASRF_KIND_TX;
                        fid_q <= tx_frame_id;
                        word_q <= (tx_ok || tx_broadcast) ? tx_addr : ASRF_ADDR_UNKNOWN;
                        b7_q <= tx_retries;
                        b8_q <= tx_broadcast ? ASRF_DS_SUCCESS : tx_delivery;
                        b9_q <= tx_discovery;
                        len_q <= ASRF_LEN_TX_STAT;
                        if (tx_frame_id != ASRF_FRAME_ID_NONE) begin
                            state_q <= ASRF_ST_HEAD;
                        end
                    end else if (cmd_valid) begin
                        kind_q <= ASRF_KIND_CMD;
                        fid_q <= cmd_frame_id;
                        word_q <= cmd_name;
                        b7_q <= cmd_status;
                        dlen_q <= cmd_has_data ? cmd_data_len : 4'h0;
                        data_q <= cmd_data;
                        len_q <= ASRF_LEN_CMD_BASE + (cmd_has_data ? {12'h000, cmd_data_len} : 16'h0000);
                        if (cmd_frame_id != ASRF_FRAME_ID_NONE) begin
                            state_q <= ASRF_ST_HEAD;
                        end
                    end
                end
                ASRF_ST_HEAD: begin
                    if (emit) begin
                        // the sum covers type byte onward only
                        if (ofs_q >= ASRF_OFS_TYPE) begin
                            sum_q <= sum_q + byte_c;
                        end
                        ofs_q <= ofs_q + 5'h01;
                        if (head_last) begin
                            dcnt_q <= 4'h0;
                            state_q <= (kind_q == ASRF_KIND_CMD && dlen_q != 4'h0) ? ASRF_ST_DATA : ASRF_ST_SUM;
                        end
                    end
                end
                ASRF_ST_DATA: begin
                    if (emit) begin
                        sum_q <= sum_q + byte_c;
                        data_q <= {data_q[55:0], 8'h00};
                        dcnt_q <= dcnt_q + 4'h1;
                        if (dcnt_q + 4'h1 == dlen_q) begin
                            state_q <= ASRF_ST_SUM;
                        end
                    end
                end
                ASRF_ST_SUM: begin
                    if (emit) begin
                        state_q <= ASRF_ST_IDLE;
                    end
                end
                default: state_q <= ASRF_ST_IDLE;
            endcase
        end
    end

    // small buffer absorbs host stalls; a full buffer stalls the sequencer
    asrf_fifo #(
        .WIDTH(9),
        .DEPTH(ASRF_FIFO_DEPTH)
    ) u_fifo (
        .clk(ref_clk),
        .rst_n(rst_n),
        .ce(clk_en),
        .in_valid(fifo_in_valid && clk_en),
        .in_ready(fifo_in_ready),
        .in_data({state_q == ASRF_ST_SUM, byte_c}),
        .out_valid(fifo_out_valid),
        .out_ready(take),
        .out_data(fifo_out)
    );

    // registered output stage; the fifo pops on every load, also into an empty stage
    assign take = clk_en && fifo_out_valid && (!out_valid || out_ready);
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_data <= 8'h00;
            out_last <= 1'b0;
        end else if (clk_en) begin
            if (out_valid && out_ready) begin
                out_valid <= fifo_out_valid;
                out_data <= fifo_out[7:0];
                out_last <= fifo_out[8];
            end else if (!out_valid && fifo_out_valid) begin
                out_valid <= 1'b1;
                out_data <= fifo_out[7:0];
                out_last <= fifo_out[8];
            end
        end
    end

    // checks
    sequence s_idle_tx0;
        clk_en && idle && !boot_pending_q && tx_valid && !modem_valid && tx_frame_id == 8'h00;
    endsequence
    a_tx_id_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        s_idle_tx0 |=> idle) else $error("tx status with id zero started a frame");
    a_cmd_id_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && cmd_ready && cmd_valid && cmd_frame_id == 8'h00 |=> idle)
        else $error("command response with id zero started a frame");
    a_boot_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(boot_pending_q) |-> kind_q == ASRF_KIND_MODEM && fid_q == 8'h00)
        else $error("first frame is not the reset status");
    a_bcast_ok: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && tx_ready && tx_valid && tx_broadcast |=> b8_q == 8'h00)
        else $error("broadcast delivery not zero");
    a_fail_addr: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && tx_ready && tx_valid && !tx_ok && !tx_broadcast |=> word_q == 16'hfffd)
        else $error("failed transmit address not fffd");
    a_type_byte: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_q == ASRF_ST_HEAD && ofs_q == 5'h03 && kind_q == ASRF_KIND_CMD |-> byte_c == 8'h88)
        else $error("command response type wrong");
    a_delim: assert property (@(posedge ref_clk) disable iff (!rst_n)
        state_q == ASRF_ST_HEAD && ofs_q == 5'h00 |-> byte_c == 8'h7e)
        else $error("frame does not open with delimiter");
    a_no_data_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clk_en && cmd_ready && cmd_valid && !cmd_has_data && cmd_frame_id != 8'h00
        |=> len_q == 16'h0005 ##0 (state_q != ASRF_ST_DATA) [*8])
        else $error("set command produced data bytes");
endmodule

// ==== design/asrf_pkg.sv ====
// package of frame constants for the api status response framer
package asrf_pkg;
    localparam logic [7:0] ASRF_DELIM = 8'h7e;
    localparam logic [7:0] ASRF_TYPE_CMD_RESP = 8'h88;
    localparam logic [7:0] ASRF_TYPE_MODEM = 8'h8a;
    localparam logic [7:0] ASRF_TYPE_TX_STAT = 8'h8b;
    localparam logic [7:0] ASRF_REQ_CMD = 8'h08;
    localparam logic [7:0] ASRF_REQ_CMD_Q = 8'h09;
    localparam logic [7:0] ASRF_REQ_TX = 8'h10;
    localparam logic [7:0] ASRF_REQ_TX_EXPL = 8'h11;
    localparam logic [7:0] ASRF_FRAME_ID_NONE = 8'h00;
    localparam logic [7:0] ASRF_CKSUM_BASE = 8'hff;
    localparam logic [15:0] ASRF_ADDR_UNKNOWN = 16'hfffd;
    // command status codes
    localparam logic [7:0] ASRF_CST_OK = 8'h00;
    localparam logic [7:0] ASRF_CST_ERROR = 8'h01;
    localparam logic [7:0] ASRF_CST_INV_CMD = 8'h02;
    localparam logic [7:0] ASRF_CST_INV_PARAM = 8'h03;
    localparam logic [7:0] ASRF_CST_TX_FAIL = 8'h04;
    // modem status codes
    localparam logic [7:0] ASRF_MS_HW_RESET = 8'h00;
    localparam logic [7:0] ASRF_MS_WDT_RESET = 8'h01;
    localparam logic [7:0] ASRF_MS_JOINED = 8'h02;
    localparam logic [7:0] ASRF_MS_DISASSOC = 8'h03;
    localparam logic [7:0] ASRF_MS_COORD_START = 8'h06;
    localparam logic [7:0] ASRF_MS_KEY_UPDATE = 8'h07;
    localparam logic [7:0] ASRF_MS_VOLT_LIMIT = 8'h0d;
    localparam logic [7:0] ASRF_MS_CFG_IN_JOIN = 8'h11;
    localparam logic [7:0] ASRF_MS_STACK_ERR = 8'h80;
    // delivery status codes
    localparam logic [7:0] ASRF_DS_SUCCESS = 8'h00;
    localparam logic [7:0] ASRF_DS_MAC_ACK = 8'h01;
    localparam logic [7:0] ASRF_DS_CCA = 8'h02;
    localparam logic [7:0] ASRF_DS_BAD_EP = 8'h15;
    localparam logic [7:0] ASRF_DS_NET_ACK = 8'h21;
    localparam logic [7:0] ASRF_DS_NOT_JOINED = 8'h22;
    localparam logic [7:0] ASRF_DS_SELF = 8'h23;
    localparam logic [7:0] ASRF_DS_ADDR_NF = 8'h24;
    localparam logic [7:0] ASRF_DS_ROUTE_NF = 8'h25;
    localparam logic [7:0] ASRF_DS_BCAST_RELAY = 8'h26;
    localparam logic [7:0] ASRF_DS_BIND_IDX = 8'h2b;
    localparam logic [7:0] ASRF_DS_RESOURCE = 8'h2c;
    localparam logic [7:0] ASRF_DS_BCAST_APS = 8'h2d;
    localparam logic [7:0] ASRF_DS_APS_NO_ENC = 8'h2e;
    localparam logic [7:0] ASRF_DS_RESOURCE2 = 8'h32;
    localparam logic [7:0] ASRF_DS_TOO_LARGE = 8'h74;
    localparam logic [7:0] ASRF_DS_INDIRECT = 8'h75;
    // discovery status codes
    localparam logic [7:0] ASRF_DISC_NONE = 8'h00;
    localparam logic [7:0] ASRF_DISC_ADDR = 8'h01;
    localparam logic [7:0] ASRF_DISC_ROUTE = 8'h02;
    localparam logic [7:0] ASRF_DISC_BOTH = 8'h03;
    localparam logic [7:0] ASRF_DISC_EXT = 8'h40;
    // frame body lengths (type byte through last field)
    localparam logic [15:0] ASRF_LEN_CMD_BASE = 16'h0005;
    localparam logic [15:0] ASRF_LEN_MODEM = 16'h0002;
    localparam logic [15:0] ASRF_LEN_TX_STAT = 16'h0007;
    // byte offsets within a frame
    localparam logic [4:0] ASRF_OFS_LEN_MSB = 5'h01;
    localparam logic [4:0] ASRF_OFS_LEN_LSB = 5'h02;
    localparam logic [4:0] ASRF_OFS_TYPE = 5'h03;
    localparam logic [4:0] ASRF_OFS_ID = 5'h04;
    localparam logic [4:0] ASRF_OFS_F5 = 5'h05;
    localparam logic [4:0] ASRF_OFS_F6 = 5'h06;
    localparam logic [4:0] ASRF_OFS_F7 = 5'h07;
    localparam logic [4:0] ASRF_OFS_F8 = 5'h08;
    localparam logic [4:0] ASRF_OFS_F9 = 5'h09;
    // command data bytes at most
    localparam int ASRF_CMD_DATA_MAX = 8;
    localparam int ASRF_FIFO_DEPTH = 4;
    localparam logic [3:0] ASRF_DATA_CNT_W = 4'h4;
    typedef enum logic [2:0] {
        ASRF_KIND_CMD = 3'b001,
        ASRF_KIND_MODEM = 3'b010,
        ASRF_KIND_TX = 3'b100
    } asrf_kind_t;
endpackage

// ==== design/asrf_sync.sv ====
// two flip-flop synchroniser with reset release
`timescale 1ns/1ps
module asrf_sync (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // level
    input wire logic d,
    output logic q
);
    logic meta_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// ==== tb/api_status_response_framer_test.sv ====
// self-checking bench for the api status response framer
`timescale 1ns/1ps
module api_status_response_framer_test;
    import asrf_pkg::*;
    logic ref_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1, stall = 1'b0, slow = 1'b0;
    logic cmd_valid = '0, cmd_has_data = '0, modem_valid = '0, tx_valid = '0, tx_ok = '0, tx_broadcast = '0;
    logic [7:0] cmd_frame_id = '0, cmd_status = '0, modem_code = '0, tx_frame_id = '0;
    logic [7:0] tx_retries = '0, tx_delivery = '0, tx_discovery = '0;
    logic [15:0] cmd_name = '0, tx_addr = '0;
    logic [3:0] cmd_data_len = 4'h1;
    logic [63:0] cmd_data = '0;
    logic cmd_ready, modem_ready, tx_ready, out_valid, out_ready, out_last;
    logic [7:0] out_data;
    int err_count = 0, samples_checked = 0;
    always #25 ref_clk = ~ref_clk;
    asrf_framer i_dut (.ref_clk, .reset_n, .clk_en, .cmd_valid, .cmd_ready, .cmd_frame_id, .cmd_name,
        .cmd_status, .cmd_has_data, .cmd_data_len, .cmd_data, .modem_valid, .modem_ready, .modem_code,
        .tx_valid, .tx_ready, .tx_frame_id, .tx_ok, .tx_broadcast, .tx_addr, .tx_retries, .tx_delivery,
        .tx_discovery, .out_valid, .out_ready, .out_data, .out_last);
    asrf_host_model i_host (.ref_clk, .out_valid, .out_ready, .out_data, .out_last, .stall, .slow);
    task automatic check8(string what, logic [7:0] exp, logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // checksum worked out here, never taken from the stream
    task automatic expect_frame(input logic [7:0] body[$]);
        logic [7:0] exp[$];
        logic [7:0] sum;
        int n;
        sum = 8'hff;
        foreach (body[i]) sum -= body[i];
        exp = {8'h7e, 8'h00, 8'(body.size()), body, sum};
        n = 0;
        while (i_host.rx_q.size() < exp.size() && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        check8("frame size", 8'(exp.size()), 8'(i_host.rx_q.size()));
        if (i_host.rx_q.size() < exp.size()) begin
            i_host.rx_q.delete();
            i_host.last_q.delete();
            return;
        end
        foreach (exp[i]) begin
            check8("frame byte", exp[i], i_host.rx_q.pop_front());
            check8("last flag", {7'h00, i == exp.size() - 1}, {7'h00, i_host.last_q.pop_front()});
        end
    endtask
    // hold the request until ready is seen ahead of the taking edge
    task automatic take(input int k);
        int n = 0;
        #1;
        while (!(k == 0 ? modem_ready : k == 1 ? tx_ready : cmd_ready) && n < 300) begin
            @(negedge ref_clk);
            #1;
            n++;
        end
        check8("request taken", 8'h01, {7'h00, n < 300});
        @(negedge ref_clk);
        modem_valid = 1'b0;
        tx_valid = 1'b0;
        cmd_valid = 1'b0;
    endtask
    task automatic send_cmd(logic [7:0] id, logic [15:0] nm, logic [7:0] st, logic hd, logic [3:0] ln,
                            logic [63:0] d);
        {cmd_frame_id, cmd_name, cmd_status, cmd_has_data, cmd_data_len, cmd_data} = {id, nm, st, hd, ln, d};
        cmd_valid = 1'b1;
        take(2);
    endtask
    task automatic send_tx(logic [7:0] id, logic ok, logic bc, logic [15:0] a, logic [7:0] r, d, s);
        {tx_frame_id, tx_ok, tx_broadcast, tx_addr, tx_retries, tx_delivery, tx_discovery} = {id, ok, bc, a, r, d, s};
        tx_valid = 1'b1;
        take(1);
    endtask
    task automatic t_modem();
        logic [7:0] codes[9] = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h0d, 8'h11, 8'h80, 8'hc3};
        expect_frame({ASRF_TYPE_MODEM, ASRF_MS_HW_RESET});
        foreach (codes[i]) begin
            modem_code = codes[i];
            modem_valid = 1'b1;
            take(0);
            expect_frame({ASRF_TYPE_MODEM, codes[i]});
        end
        $display("test modem status done");
    endtask
    task automatic t_cmd();
        for (int s = 0; s < 5; s++) begin
            send_cmd(8'h01, 16'h4244, 8'(s), 1'b0, 4'h1, 64'h0);
            expect_frame({ASRF_TYPE_CMD_RESP, 8'h01, 8'h42, 8'h44, 8'(s)});
        end
        send_cmd(8'hb7, 16'h4142, ASRF_CST_OK, 1'b1, 4'h8, 64'h0102_0304_0506_0708);
        expect_frame({8'h88, 8'hb7, 8'h41, 8'h42, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04,
                      8'h05, 8'h06, 8'h07, 8'h08});
        // zero ids are taken but answered by nothing
        send_cmd(8'h00, 16'h4244, 8'h00, 1'b0, 4'h1, 64'h0);
        send_tx(8'h00, 1'b1, 1'b0, 16'h1234, 8'h00, 8'h00, 8'h00);
        repeat (40) @(negedge ref_clk);
        check8("silent bytes", 8'h00, 8'(i_host.rx_q.size()));
        $display("test command response done");
    endtask
    task automatic t_tx();
        logic [7:0] dl[16] = '{8'h01, 8'h02, 8'h15, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h2b, 8'h2c,
                               8'h2d, 8'h2e, 8'h32, 8'h74, 8'h75};
        logic [7:0] ds[5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h40};
        send_tx(8'h01, 1'b1, 1'b0, 16'h7d84, 8'h00, 8'h00, 8'h01);
        expect_frame({8'h8b, 8'h01, 8'h7d, 8'h84, 8'h00, 8'h00, 8'h01});
        foreach (dl[i]) begin
            send_tx(8'(i + 2), 1'b0, 1'b0, 16'h1234, 8'(i), dl[i], ds[i % 5]);
            expect_frame({8'h8b, 8'(i + 2), 8'hff, 8'hfd, 8'(i), dl[i], ds[i % 5]});
        end
        send_tx(8'h5a, 1'b0, 1'b1, 16'hfffe, 8'h02, 8'h21, 8'h40);
        expect_frame({8'h8b, 8'h5a, 8'hff, 8'hfe, 8'h02, 8'h00, 8'h40});
        $display("test transmit status done");
    endtask
    task automatic t_stall();
        stall = 1'b1;
        send_cmd(8'h33, 16'h4e44, 8'h00, 1'b1, 4'h2, 64'h1234_0000_0000_0000);
        repeat (30) @(negedge ref_clk);
        check8("bytes while stalled", 8'h00, 8'(i_host.rx_q.size()));
        check8("valid held", 8'h01, {7'h00, out_valid});
        stall = 1'b0;
        slow = 1'b1;
        send_cmd(8'h33, 16'h4e44, 8'h00, 1'b1, 4'h1, 64'h5600_0000_0000_0000);
        expect_frame({8'h88, 8'h33, 8'h4e, 8'h44, 8'h00, 8'h12, 8'h34});
        expect_frame({8'h88, 8'h33, 8'h4e, 8'h44, 8'h00, 8'h56});
        slow = 1'b0;
        $display("test stalled host done");
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        $display("BAD watchdog expected end seen hang");
        complete_run();
    end
    initial begin
        repeat (4) @(negedge ref_clk);
        reset_n = 1'b1;
        t_modem();
        t_cmd();
        t_tx();
        t_stall();
        complete_run();
    end
endmodule

// ==== tb/asrf_host_model.sv ====
// host side model: takes api bytes, can stall or pace them
`timescale 1ns/1ps
module asrf_host_model (
    // clock
    input wire logic ref_clk,
    // byte stream from the framer
    input wire logic out_valid,
    output logic out_ready,
    input wire logic [7:0] out_data,
    input wire logic out_last,
    // pacing set by the bench
    input wire logic stall,
    input wire logic slow
);
    logic [7:0] rx_q[$];
    logic last_q[$];
    logic ph = 1'b0;
    initial out_ready = 1'b0;
    // a host takes any number of frames in a row, at full rate, every other cycle when slow, or none while stalled
    always @(negedge ref_clk) begin
        ph <= ~ph;
        out_ready <= !stall && (!slow || ph);
    end
    // bytes kept whole in order; framing is judged by the bench
    always @(posedge ref_clk) begin
        if (out_valid && out_ready) begin
            rx_q.push_back(out_data);
            last_q.push_back(out_last);
        end
    end
endmodule
